// File: hdl/phy_mgmt.sv
//  Contract
// [RL1] alternate clearing only while select bit set
// [RL2] mask bit enables source onto interrupt
// [RL3] clearing mask bit drops interrupt at once
// [RL4] write one clears flag only if condition gone
// [RL5] seven sources, link down uses falling edge
// [RL6] energy detect rise asserts interrupt when enabled
// [RL7] energy flag reads one after power-up
// [RL8] straps caught at power-on and pin reset
// [RL9] address strap latched at reset end, default zero
// [RL10] answer only frames carrying our address
// [RL11] address seeds the transmit scrambler
// [RL12] strap gives 0 or 1, software sets more
// [RL13] address strap shares receive error pin
// [RL14] pin reset release loads mode strap defaults
// [RL15] soft reset keeps registers, no strap reload; code resets alt, mask and flags, and keeps ctl and adv
// [RL16] codes 000..011 force speed and duplex
// [RL17] codes 100,101 advertise half duplex 100
// [RL18] code 111 advertises everything
// [RL19] code 110 powers down until soft reset; code stays powered down if mode still reads 110
// [RL20] carrier on transmit only in half duplex
// [RL21] mode straps sampled on receive data pins
// [RL22] primary scheme selected after every reset
// [RL23] interrupt output active low
// [RL24] unused flag and mask bits read zero
`include "phy_mgmt_cfg.svh"
`timescale 1ns/10ps

module phy_mgmt (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 pin_reset_n_i,
  input  wire logic                 mdc_i,
  input  wire logic                 mdio_i,
  output logic                      mdio_o,
  output logic                      mdio_oe_n_o,
  input  wire logic                 addr_strap_bit0_i,
  input  wire logic                 rxd0_mode_i,
  input  wire logic                 rxd1_mode_i,
  input  wire logic                 crs_dv_mode_i,
  input  wire phy_mgmt_pkg::src_t   src_i,
  output phy_mgmt_pkg::cfg_out_t    cfg_o,
  output logic                      irq_out_n_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [6:0] pins_s;
  logic       pin_ok;
  logic       mdc_s;
  logic       mdio_s;
  logic       addr_s;
  logic [2:0] mode_s;

  // pin reset, clock, data and straps share one synchroniser bank
  pin_sync #(
    .W   (7),
    .RST ({1'b0, 1'b1, 1'b1, 1'b0, `MODE_DFLT})
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({pin_reset_n_i, mdc_i, mdio_i, addr_strap_bit0_i,
             crs_dv_mode_i, rxd1_mode_i, rxd0_mode_i}),  // see [RL21] [RL13]
    .q_o   (pins_s)
  );

  assign pin_ok = pins_s[6];
  assign mdc_s  = pins_s[5];
  assign mdio_s = pins_s[4];
  assign addr_s = pins_s[3];
  assign mode_s = pins_s[2:0];

  ////////////////////////////////////////////////////////////////////////////////
  // reset image

  function automatic phy_mgmt_pkg::state_t rst_state();
    phy_mgmt_pkg::state_t s;
    s           = '0;
    s.st        = phy_mgmt_pkg::SMI_IDLE;
    s.mdc_prev  = 1'b1;
    s.mdio_o    = 1'b1;
    s.mdio_oe_n = 1'b1;
    s.flags     = `FLAG_RST;  // see [RL7]
    s.act_prev  = `ACT_RST;   // no false link-down edge at power-up
    s.alt       = 1'b0;       // see [RL22]
    s.pending   = 1'b1;       // see [RL8]
    s.crs_tx    = 1'b1;
    s.irq_n     = 1'b1;
    return s;
  endfunction : rst_state

  localparam phy_mgmt_pkg::state_t RST_S = rst_state();

  phy_mgmt_pkg::state_t q;
  phy_mgmt_pkg::state_t n;

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  function automatic logic [15:0] rd_val(input phy_mgmt_pkg::state_t s,
                                         input phy_mgmt_pkg::src_t   v,
                                         input logic [4:0]           ra);
    logic [15:0] r;
    r = 16'h0000;
    unique case (ra)
      `REG_BCR:
      begin
        r[`BCR_SPEED]  = s.ctl[3];
        r[`BCR_ANEN]   = s.ctl[2];
        r[`BCR_B10]    = s.ctl[1];
        r[`BCR_DUPLEX] = s.ctl[0];
      end
      `REG_BSR:
      begin
        r[`BSR_ANDONE] = v.an_done;
        r[`BSR_RFAULT] = v.rfault;
        r[`BSR_LINK]   = v.link;
      end
      `REG_ADV: r[8:5]        = s.adv;
      `REG_LPA: r[`LPA_ACK]   = v.lp_ack;
      `REG_ANX:
      begin
        r[`ANX_PDF]  = v.pd_fault;
        r[`ANX_PAGE] = v.page_rx;
      end
      `REG_MCS:
      begin
        r[`MCS_ALT]    = s.alt;
        r[`MCS_ENERGY] = v.energy;
      end
      `REG_SMR: r[7:0] = {s.mode, s.addr};
      `REG_ISF: r[7:0] = s.flags & `IRQ_SRC;  // see [RL24]
      `REG_IMR: r[7:0] = s.mask & `IRQ_SRC;
      default:
        if (ra >= `REG_HOLE_LO && ra <= `REG_HOLE_HI)
          r = `HOLE_VALUE;
    endcase
    return r;
  endfunction : rd_val

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic        rise;
  logic [13:0] hdr_full;
  logic        rd_hit;
  logic        wr_hit;
  logic [4:0]  rd_ra;
  logic [15:0] wdat;
  logic [7:0]  act;
  logic [7:0]  evt;
  logic [7:0]  clr;

  always_comb
  begin
    n        = q;
    rd_hit   = 1'b0;
    wr_hit   = 1'b0;
    wdat     = 16'h0000;
    rd_ra    = 5'h00;
    clr      = 8'h00;
    rise     = mdc_s & ~q.mdc_prev;
    hdr_full = {q.hdr[12:0], mdio_s};
    n.mdc_prev = mdc_s;

    // frame engine, every bit taken on a rising management clock edge
    unique case (q.st)
      phy_mgmt_pkg::SMI_IDLE:
        if (rise)
        begin
          if (mdio_s)
            n.ones = (q.ones == `PREAMBLE_LEN) ? q.ones : q.ones + 6'h01;
          else if (q.ones == `PREAMBLE_LEN)
          begin
            n.st   = phy_mgmt_pkg::SMI_HDR;
            n.cnt  = 5'h00;
            n.hdr  = 14'h0000;
            n.ones = 6'h00;
          end
          else
            n.ones = 6'h00;
        end
      phy_mgmt_pkg::SMI_HDR:
        if (rise)
        begin
          n.hdr = hdr_full;
          n.cnt = q.cnt + 5'h01;
          if (q.cnt == `HDR_LAST)
          begin
            // foreign address or bad opcode: stay off the line
            if (hdr_full[13:12] == `ST_CODE && hdr_full[9:5] == q.addr &&
                (hdr_full[11:10] == `OP_RD || hdr_full[11:10] == `OP_WR))  // see [RL10]
            begin
              n.st    = phy_mgmt_pkg::SMI_TA;
              n.cnt   = 5'h00;
              n.ra    = hdr_full[4:0];
              n.is_rd = (hdr_full[11:10] == `OP_RD);
              if (hdr_full[11:10] == `OP_RD)
              begin
                rd_hit = 1'b1;
                rd_ra  = hdr_full[4:0];
                n.sh   = rd_val(q, src_i, hdr_full[4:0]);
              end
            end
            else
              n.st = phy_mgmt_pkg::SMI_IDLE;
          end
        end
      phy_mgmt_pkg::SMI_TA:
        if (rise)
        begin
          if (q.cnt == 5'h00)
          begin
            n.cnt = 5'h01;
            if (q.is_rd)
            begin
              n.mdio_o    = 1'b0;
              n.mdio_oe_n = 1'b0;
            end
          end
          else if (q.is_rd)
          begin
            n.mdio_o = q.sh[15];
            n.sh     = {q.sh[14:0], 1'b0};
            n.cnt    = `DATA_LAST;
            n.st     = phy_mgmt_pkg::SMI_RD;
          end
          else
          begin
            n.cnt = 5'h00;
            n.st  = phy_mgmt_pkg::SMI_WR;
          end
        end
      phy_mgmt_pkg::SMI_RD:
        if (rise)
        begin
          if (q.cnt == 5'h00)
          begin
            n.mdio_o    = 1'b1;
            n.mdio_oe_n = 1'b1;
            n.st        = phy_mgmt_pkg::SMI_IDLE;
          end
          else
          begin
            n.mdio_o = q.sh[15];
            n.sh     = {q.sh[14:0], 1'b0};
            n.cnt    = q.cnt - 5'h01;
          end
        end
      phy_mgmt_pkg::SMI_WR:
        if (rise)
        begin
          n.sh  = {q.sh[14:0], mdio_s};
          n.cnt = q.cnt + 5'h01;
          if (q.cnt == `DATA_LAST)
          begin
            wr_hit = 1'b1;
            wdat   = {q.sh[14:0], mdio_s};
            n.st   = phy_mgmt_pkg::SMI_IDLE;
          end
        end
      default:
        n.st = phy_mgmt_pkg::SMI_IDLE;
    endcase

    // source levels, link status counts when it is low
    act        = {src_i.energy, src_i.an_done, src_i.rfault, src_i.link,
                  src_i.lp_ack, src_i.pd_fault, src_i.page_rx, 1'b0} ^ `IRQ_POL;  // see [RL5]
    evt        = act & ~q.act_prev & `IRQ_SRC;  // see [RL6]
    n.act_prev = act;

    // register writes
    if (wr_hit)
    begin
      unique case (q.ra)
        `REG_BCR:
          if (wdat[`BCR_SRST])
          begin
            // soft reset leaves configuration as software left it
            n.alt        = 1'b0;
            n.flags      = `FLAG_RST;
            n.mask       = 8'h00;
            n.power_down = (q.mode == `MODE_PDN);  // see [RL15] [RL19]
          end
          else
            n.ctl = {wdat[`BCR_SPEED], wdat[`BCR_ANEN], wdat[`BCR_B10], wdat[`BCR_DUPLEX]};
        `REG_ADV: n.adv  = wdat[8:5];
        `REG_MCS: n.alt  = wdat[`MCS_ALT];
        `REG_SMR: {n.mode, n.addr} = wdat[7:0];  // see [RL12]
        `REG_ISF:
          if (q.alt)
            clr = wdat[7:0] & ~act;  // see [RL4] [RL1]
        `REG_IMR: n.mask = wdat[7:0] & `IRQ_SRC;  // see [RL2] [RL24]
        default: ;
      endcase
    end

    // primary scheme clears on the opposite level (all sources but link down) or on a read
    if (!q.alt)
    begin
      clr = clr | (~act & `PRIM_LVL_CLR);
      if (rd_hit && rd_ra == `REG_ISF)
        clr = clr | `RDCLR_ISF;
      if (rd_hit && rd_ra == `REG_BSR)
        clr = clr | `RDCLR_BSR;
      if (rd_hit && rd_ra == `REG_ANX)
        clr = clr | `RDCLR_ANX;
    end
    // a new event beats a clear in the same cycle
    n.flags = (evt | (n.flags & ~clr)) & `IRQ_SRC;

    // hard reset holds everything, its release loads the straps
    if (!pin_ok)
      n = RST_S;  // see [RL8]
    else if (q.pending)
    begin
      n.pending    = 1'b0;
      n.mode       = mode_s;  // see [RL14]
      n.addr       = {4'h0, addr_s};  // see [RL9] [RL11]
      n.repeater   = (mode_s == `MODE_RPT);
      n.power_down = (mode_s == `MODE_PDN);  // see [RL19]
      unique case (mode_s)
        `MODE_10HD:  {n.ctl, n.adv} = {`CTL_10HD, `ADV_NONE};  // see [RL16]
        `MODE_10FD:  {n.ctl, n.adv} = {`CTL_10FD, `ADV_NONE};
        `MODE_100HD: {n.ctl, n.adv} = {`CTL_100HD, `ADV_NONE};
        `MODE_100FD: {n.ctl, n.adv} = {`CTL_100FD, `ADV_NONE};
        `MODE_AN_HD: {n.ctl, n.adv} = {`CTL_AN_HD, `ADV_HD100};  // see [RL17]
        `MODE_RPT:   {n.ctl, n.adv} = {`CTL_AN_HD, `ADV_HD100};
        `MODE_PDN:   {n.ctl, n.adv} = {`CTL_10HD, `ADV_NONE};
        `MODE_ALL:   {n.ctl, n.adv} = {`CTL_ALL, `ADV_ALL};  // see [RL18]
      endcase
    end

    n.crs_tx = ~n.ctl[0] & ~n.repeater;  // see [RL20]
    n.irq_n  = ~|(n.flags & n.mask);      // see [RL3] [RL23]
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= RST_S;
    else
      q <= n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign mdio_o      = q.mdio_o;
  assign mdio_oe_n_o = q.mdio_oe_n;
  assign irq_out_n_o = q.irq_n;
  assign cfg_o       = '{speed_100: q.ctl[3], an_enable: q.ctl[2], ctl_b10: q.ctl[1],
                         full_duplex: q.ctl[0], advert: q.adv, repeater: q.repeater,
                         crs_on_tx: q.crs_tx, power_down: q.power_down, phy_addr: q.addr};

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_hdr_rd;
    q.st == phy_mgmt_pkg::SMI_HDR && rise && q.cnt == `HDR_LAST && pin_ok &&
    hdr_full[13:12] == `ST_CODE && hdr_full[11:10] == `OP_RD && hdr_full[9:5] == q.addr;
  endsequence

  sequence s_ta_release;
    q.st == phy_mgmt_pkg::SMI_TA && q.mdio_oe_n;
  endsequence

  a_irq_mask_gate: assert property (q.irq_n == ~|(q.flags & q.mask))  // see [RL2]
    else $error("interrupt output disagrees with flags and mask");
  a_mask_clear_irq: assert property ((wr_hit && q.ra == `REG_IMR && wdat[7:1] == 7'h00
    && pin_ok) |=> irq_out_n_o)  // see [RL3]
    else $error("interrupt stayed low after mask cleared");
  a_alt_w1c_hold: assert property ((pin_ok && q.alt && wr_hit && q.ra == `REG_ISF && wdat[7]
    && q.flags[7] && src_i.energy) |=> q.flags[7])  // see [RL4]
    else $error("flag cleared while source still active");
  a_alt_w1c_clear: assert property ((pin_ok && q.alt && wr_hit && q.ra == `REG_ISF && wdat[7]
    && !src_i.energy) |=> !q.flags[7])  // see [RL4]
    else $error("flag kept after write one with source gone");
  a_energy_irq: assert property ((pin_ok && !q.pending && src_i.energy && !q.act_prev[7]
    && q.mask[7]) |=> !irq_out_n_o)  // see [RL6]
    else $error("energy rise did not assert interrupt");
  a_strap_addr: assert property ((q.pending && pin_ok) |=> cfg_o.phy_addr == {4'h0, $past(addr_s)})  // see [RL9]
    else $error("address strap not latched");
  a_strap_pdn: assert property ((q.pending && pin_ok && mode_s == `MODE_PDN) |=> q.power_down)  // see [RL19]
    else $error("power-down strap not applied");
  a_alt_reset: assert property (!pin_ok |=> !q.alt && q.pending)  // see [RL22]
    else $error("alternate select survived hard reset");
  a_softrst_keep: assert property ((pin_ok && !q.pending && wr_hit && q.ra == `REG_BCR
    && wdat[`BCR_SRST]) |=> $stable(q.ctl) && $stable(q.adv))  // see [RL15]
    else $error("soft reset changed configuration");
  a_read_turn: assert property (s_hdr_rd |=> s_ta_release)  // see [RL10]
    else $error("read did not enter turnaround released");
  a_resvd_zero: assert property (q.flags[0] == 1'b0 && q.mask[0] == 1'b0)  // see [RL24]
    else $error("unused interrupt bit set");

endmodule : phy_mgmt

// File: hdl/phy_mgmt_cfg.svh
`ifndef PHY_MGMT_CFG_SVH
`define PHY_MGMT_CFG_SVH

// register addresses on the management interface
`define REG_BCR        5'h00
`define REG_BSR        5'h01
`define REG_ADV        5'h04
`define REG_LPA        5'h05
`define REG_ANX        5'h06
`define REG_MCS        5'h11
`define REG_SMR        5'h12
`define REG_ISF        5'h1D
`define REG_IMR        5'h1E
`define REG_HOLE_LO    5'h07
`define REG_HOLE_HI    5'h0F
`define HOLE_VALUE     16'hFFFF

// field positions
`define BCR_SRST       15
`define BCR_SPEED      13
`define BCR_ANEN       12
`define BCR_B10        10
`define BCR_DUPLEX     8
`define BSR_ANDONE     5
`define BSR_RFAULT     4
`define BSR_LINK       2
`define LPA_ACK        14
`define ANX_PDF        4
`define ANX_PAGE       1
`define MCS_ALT        6
`define MCS_ENERGY     1

// interrupt source bit groups, bit 0 carries no source
`define IRQ_SRC        8'hFE
`define IRQ_POL        8'h10
`define FLAG_RST       8'h80
`define ACT_RST        8'h90
`define PRIM_LVL_CLR   8'hEE
`define RDCLR_ISF      8'hFE
`define RDCLR_BSR      8'h30
`define RDCLR_ANX      8'h06

// management frame
`define PREAMBLE_LEN   6'h20
`define OP_RD          2'h2
`define OP_WR          2'h1
`define ST_CODE        2'h1
`define HDR_LAST       5'h0C
`define DATA_LAST      5'h0F

// mode strap codes and what they load
`define MODE_10HD      3'h0
`define MODE_10FD      3'h1
`define MODE_100HD     3'h2
`define MODE_100FD     3'h3
`define MODE_AN_HD     3'h4
`define MODE_RPT       3'h5
`define MODE_PDN       3'h6
`define MODE_ALL       3'h7
`define MODE_DFLT      3'h7
`define CTL_10HD       4'h0
`define CTL_10FD       4'h1
`define CTL_100HD      4'h8
`define CTL_100FD      4'h9
`define CTL_AN_HD      4'hC
`define CTL_ALL        4'hD
`define ADV_NONE       4'h0
`define ADV_HD100      4'h4
`define ADV_ALL        4'hF

`endif

// File: hdl/phy_mgmt_pkg.sv
package phy_mgmt_pkg;

  // live status from the 10/100 core, same clock
  typedef struct packed {
    logic energy;
    logic an_done;
    logic rfault;
    logic link;
    logic lp_ack;
    logic pd_fault;
    logic page_rx;
  } src_t;

  // configuration driven into the 10/100 core
  typedef struct packed {
    logic       speed_100;
    logic       an_enable;
    logic       ctl_b10;
    logic       full_duplex;
    logic [3:0] advert;
    logic       repeater;
    logic       crs_on_tx;
    logic       power_down;
    logic [4:0] phy_addr;
  } cfg_out_t;

  typedef enum logic [2:0] {SMI_IDLE, SMI_HDR, SMI_TA, SMI_RD, SMI_WR} smi_st_t;

  typedef struct packed {
    smi_st_t     st;
    logic [5:0]  ones;
    logic [4:0]  cnt;
    logic [13:0] hdr;
    logic [15:0] sh;
    logic        is_rd;
    logic [4:0]  ra;
    logic        mdc_prev;
    logic        mdio_o;
    logic        mdio_oe_n;
    logic [3:0]  ctl;
    logic [3:0]  adv;
    logic        alt;
    logic [2:0]  mode;
    logic [4:0]  addr;
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic [7:0]  act_prev;
    logic        pending;
    logic        power_down;
    logic        repeater;
    logic        crs_tx;
    logic        irq_n;
  } state_t;

endpackage : phy_mgmt_pkg

// File: hdl/pin_sync.sv
`timescale 1ns/10ps

// three-stage pin synchroniser, output moves once stages two and three agree
module pin_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic [W-1:0]      q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_st_t;

  sync_st_t q;
  sync_st_t d;

  // stage one feeds stage two only, so metastability never leaks further
  always_comb
  begin
    d    = q;
    d.s1 = d_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.q  = (q.s2 == q.s3) ? q.s3 : q.q;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      q <= {RST, RST, RST, RST};
    else
      q <= d;
  end

  assign q_o = q.q;

endmodule : pin_sync

// File: verif/smi_ctrl_model.sv
`timescale 1ns/10ps

// station management controller: bit-banged frames, 48 ns mdc phases
module smi_ctrl_model (
  input  wire logic clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_en_o
);

  // idle: clock parked low, line released to its pull-up
  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_en_o = 1'b0;
  end

  ////////////////////////////////////////
  // data moves while mdc is low, the line is taken just before the rise
  task automatic bit_cyc(input logic b, output logic s);
    mdio_o = b;
    repeat (6) @(posedge clk_i);
    #1;
    s = mdio_i;
    mdc_o = 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    mdc_o = 1'b0;
  endtask : bit_cyc

  // one whole frame; on a read the line is released from turnaround on
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, rd ? 2'b10 : 2'b01, pa, ra};
    mdio_en_o = 1'b1;
    repeat (32) bit_cyc(1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], s);
    mdio_en_o = !rd;
    bit_cyc(1'b1, s);
    bit_cyc(1'b0, s);
    for (int i = 15; i >= 0; i--) bit_cyc(wd[i], rdat[i]);
    mdio_en_o = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
  endtask : frame

endmodule : smi_ctrl_model

// File: verif/phy_mgmt_tb.sv
`timescale 1ns/10ps

module phy_mgmt_tb;
  logic                   clk_i;
  logic                   rst_i;
  logic                   pin_reset_n_i;
  logic                   mdc;
  logic                   m_out;
  logic                   m_en;
  logic                   mdio_o;
  logic                   mdio_oe_n_o;
  logic                   irq_n;
  logic                   addr_s;
  logic [2:0]             mode_s;
  logic [6:0]             src_v;
  phy_mgmt_pkg::cfg_out_t cfg;
  logic [15:0]            rd;
  logic                   drove_seen;
  int                     miscompares;
  int                     tests_run;
  wire logic              mdio_w;

  // {ctl 13,12,10,8, advert, repeater, crs_on_tx, power_down} per strap code
  localparam logic [10:0] STRAP_EXP [8] = '{11'h002, 11'h080, 11'h402, 11'h480,
                                            11'h622, 11'h624, 11'h003, 11'h6f8};

  // wire level: device when enabled, else controller, else pull-up
  assign mdio_w = !mdio_oe_n_o ? mdio_o : (m_en ? m_out : 1'b1);

  smi_ctrl_model smi (
    .clk_i     (clk_i),
    .mdio_i    (mdio_w),
    .mdc_o     (mdc),
    .mdio_o    (m_out),
    .mdio_en_o (m_en)
  );

  phy_mgmt DUT (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .pin_reset_n_i     (pin_reset_n_i),
    .mdc_i             (mdc),
    .mdio_i            (mdio_w),
    .mdio_o            (mdio_o),
    .mdio_oe_n_o       (mdio_oe_n_o),
    .addr_strap_bit0_i (addr_s),
    .rxd0_mode_i       (mode_s[0]),
    .rxd1_mode_i       (mode_s[1]),
    .crs_dv_mode_i     (mode_s[2]),
    .src_i             (phy_mgmt_pkg::src_t'(src_v)),
    .cfg_o             (cfg),
    .irq_out_n_o       (irq_n)
  );

  // remembers any drive of the line, a foreign frame must leave it alone
  always @(posedge clk_i)
    if (mdio_oe_n_o === 1'b0)
      drove_seen <= 1'b1;

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_pin(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t pin %b expected %b", $time, got, exp);
    end
  endtask : chk_pin

  task automatic tally_and_finish;
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // returns 1 ns after an edge so inputs never move on the sampling edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_clk

  task automatic rd_reg(input logic [4:0] pa, input logic [4:0] ra, output logic [15:0] d);
    smi.frame(1'b1, pa, ra, 16'h0000, d);
  endtask : rd_reg

  task automatic wr_reg(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] unused;
    smi.frame(1'b0, pa, ra, wd, unused);
  endtask : wr_reg

  // flip one source level, then give the unsynchronised flag and interrupt logic time to settle
  task automatic flip(input int b);
    src_v[b] = ~src_v[b];
    wait_clk(8);
  endtask : flip

  function automatic logic [15:0] cfg_w(input phy_mgmt_pkg::cfg_out_t c);
    return {5'h00, c.speed_100, c.an_enable, c.ctl_b10, c.full_duplex, c.advert,
            c.repeater, c.crs_on_tx, c.power_down};
  endfunction : cfg_w

  ////////////////////////////////////////
  task automatic t_power_up;
    chk_word(cfg_w(cfg), {5'h00, STRAP_EXP[7]});
    chk_pin(irq_n, 1'b1);
    rd_reg(5'h00, 5'h1d, rd);
    chk_word(rd, 16'h0080);
    rd_reg(5'h00, 5'h11, rd);
    chk_word(rd, 16'h0002);
    rd_reg(5'h00, 5'h1e, rd);
    chk_word(rd, 16'h0000);
    src_v[6] = 1'b0;
  endtask : t_power_up

  task automatic t_address;
    drove_seen = 1'b0;
    rd_reg(5'h01, 5'h1e, rd);
    chk_word(rd, 16'hffff);
    chk_pin(drove_seen, 1'b0);
    wr_reg(5'h00, 5'h12, 16'h00e5);
    chk_word({11'h000, cfg.phy_addr}, 16'h0005);
    rd_reg(5'h05, 5'h12, rd);
    chk_word(rd, 16'h00e5);
  endtask : t_address

  task automatic t_alternate;
    wr_reg(5'h05, 5'h11, 16'h0040);
    wr_reg(5'h05, 5'h1e, 16'hffff);
    rd_reg(5'h05, 5'h1e, rd);
    chk_word(rd, 16'h00fe);
    chk_pin(irq_n, 1'b1);
    for (int k = 1; k <= 7; k++)
    begin
      flip(k - 1);
      chk_pin(irq_n, 1'b0);
      rd_reg(5'h05, 5'h1d, rd);
      chk_word(rd, 16'h0001 << k);
      wr_reg(5'h05, 5'h1d, 16'h0001 << k);
      chk_pin(irq_n, 1'b0);
      flip(k - 1);
      chk_pin(irq_n, 1'b0);
      wr_reg(5'h05, 5'h1d, 16'h0001 << k);
      chk_pin(irq_n, 1'b1);
    end
    flip(0);
    chk_pin(irq_n, 1'b0);
    wr_reg(5'h05, 5'h1e, 16'h0000);
    chk_pin(irq_n, 1'b1);
    flip(0);
  endtask : t_alternate

  // code order ends on power-down so the soft reset scenario can leave it
  task automatic t_straps;
    logic [2:0] code;
    for (int i = 0; i < 8; i++)
    begin
      code = 3'(i) ^ 3'h1;
      mode_s = code;
      addr_s = code[0];
      wait_clk(6);
      pin_reset_n_i = 1'b0;
      wait_clk(10);
      pin_reset_n_i = 1'b1;
      wait_clk(20);
      chk_word(cfg_w(cfg), {5'h00, STRAP_EXP[code]});
      chk_word({11'h000, cfg.phy_addr}, {15'h0000, code[0]});
      addr_s = ~code[0];
      wait_clk(10);
      chk_word({11'h000, cfg.phy_addr}, {15'h0000, code[0]});
    end
  endtask : t_straps

  task automatic t_soft_reset;
    mode_s = 3'h3;
    wr_reg(5'h00, 5'h12, 16'h00e0);
    chk_word(cfg_w(cfg), 16'h0003);
    wr_reg(5'h00, 5'h00, 16'h8000);
    chk_word(cfg_w(cfg), 16'h0002);
  endtask : t_soft_reset

  ////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    pin_reset_n_i = 1'b1;
    addr_s = 1'b0;
    mode_s = 3'h7;
    src_v = 7'b1001000;
    drove_seen = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (5) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    wait_clk(20);
    t_power_up();
    t_address();
    t_alternate();
    t_straps();
    t_soft_reset();
    tally_and_finish();
  end

  // the run needs about 26000 cycles, reaching the 60000-cycle limit means a hang
  initial
  begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end

endmodule : phy_mgmt_tb
